// File: logic/internal_osc_clock_select.sv
// Internal oscillator enable, status, trim and glitch-free switch control
`timescale 1ns/1ns
`default_nettype none
module internal_osc_clock_select #(
   parameter int ADDR_W        = 12,
   parameter int MULT_LOCK_CYC = osc_sel_pkg::MULT_LOCK_CYC
) (
   input  wire logic              CLK_SYS_IN,
   input  wire logic              RST_B_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [ADDR_W-1:0] PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic      [31:0]       PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   input  wire logic [1:0]        CFG_DEFAULT_SRC_IN,
   input  wire logic              CFG_MULT_FORCE_IN,
   input  wire logic              CFG_CLOCK_OUT_PIN_EN_IN,
   input  wire logic              LF_CONSUMER_REQ_IN,
   input  wire logic              PERIPH_RC_REQ_IN,
   output logic                   HF_OSC_EN_OUT,
   output logic                   MF_OSC_EN_OUT,
   output logic                   LF_OSC_EN_OUT,
   output logic                   MULT_EN_OUT,
   output logic                   RC_CLK_EN_OUT,
   output logic      [5:0]        TRIM_OUT,
   output logic      [3:0]        ACTIVE_FREQ_OUT,
   output logic                   ACTIVE_MULT_OUT,
   output logic                   INTERNAL_SRC_OUT,
   output logic                   CLK_HOLD_LOW_OUT,
   output logic                   CLOCK_IN_PIN_GPIO_OUT,
   output logic                   CLOCK_OUT_PIN_FUNC_OUT
);

   localparam int W = osc_sel_pkg::CNT_W;

   typedef enum logic [4:0] {
      SW_IDLE  = 5'b00001,
      SW_START = 5'b00010,
      SW_FALL  = 5'b00100,
      SW_SYNC  = 5'b01000,
      SW_DONE  = 5'b10000
   } sw_state_e;

   // Source oscillator that a frequency code draws on
   function automatic osc_sel_pkg::osc_src_e src_of(input logic [3:0] code);
      if (code[3] || code == 4'h3) begin
         src_of = osc_sel_pkg::SRC_HF;
      end else if (code[2] || code == 4'h2) begin
         src_of = osc_sel_pkg::SRC_MF;
      end else begin
         src_of = osc_sel_pkg::SRC_LF;
      end
   endfunction : src_of

   // Saturating warm-up counter step
   function automatic logic [W-1:0] warm(input logic en,
                                         input logic [W-1:0] cnt);
      if (!en) begin
         warm = '0;
      end else if (cnt == '1) begin
         warm = cnt;
      end else begin
         warm = cnt + W'(1);
      end
   endfunction : warm

   logic             mult_sw_q;
   logic [3:0]       freq_q;
   logic [1:0]       src_q;
   logic [5:0]       trim_q;
   logic [3:0]       active_freq_q;
   logic [3:0]       target_q;
   logic [1:0]       sync_cnt_q;
   logic [W-1:0]     hf_cnt_q;
   logic [W-1:0]     mf_cnt_q;
   logic [W-1:0]     lf_cnt_q;
   logic [W-1:0]     mult_cnt_q;
   logic [6:0]       status_q;
   sw_state_e        state_q;
   logic             internal_sel;
   logic             mult_on;
   logic             hf_need;
   logic             mf_need;
   logic             lf_need;
   logic             hf_rdy;
   logic             mf_rdy;
   logic             lf_rdy;
   logic             target_rdy;
   logic             apb_access;
   logic             apb_write;
   logic [ADDR_W-1:0] ofs_ctrl;
   logic [ADDR_W-1:0] ofs_status;
   logic [ADDR_W-1:0] ofs_trim;
   osc_sel_pkg::osc_src_e req_src;
   osc_sel_pkg::osc_src_e act_src;
   osc_sel_pkg::osc_src_e tgt_src;

   assign ofs_ctrl   = ADDR_W'(osc_sel_pkg::CTRL_OFS);
   assign ofs_status = ADDR_W'(osc_sel_pkg::STATUS_OFS);
   assign ofs_trim   = ADDR_W'(osc_sel_pkg::TRIM_OFS);

   // Internal block drives the system clock: by default configuration
   // under select 00, or by run-time select 1x
   assign internal_sel = src_q[1] ||
      (src_q == osc_sel_pkg::SRC_DEFAULT &&
       CFG_DEFAULT_SRC_IN == osc_sel_pkg::CFG_INTERNAL);

   // Multiplier path; the force bit overrides the software bit
   assign mult_on = CFG_DEFAULT_SRC_IN == osc_sel_pkg::CFG_INTERNAL &&
                    src_q == osc_sel_pkg::SRC_DEFAULT &&
                    freq_q == osc_sel_pkg::FREQ_8M_32M &&
                    (mult_sw_q || CFG_MULT_FORCE_IN);

   assign req_src = src_of(freq_q);
   assign act_src = src_of(active_freq_q);
   assign tgt_src = src_of(target_q);

   // The oscillator feeding the running clock stays on until the switch
   // is over, so the old clock never stops under the CPU
   assign hf_need = (internal_sel && req_src == osc_sel_pkg::SRC_HF) ||
                    (act_src == osc_sel_pkg::SRC_HF) ||
                    (state_q != SW_IDLE &&
                     tgt_src == osc_sel_pkg::SRC_HF);
   // High source is built from the mid oscillator, so it needs it too
   assign mf_need = (internal_sel && req_src == osc_sel_pkg::SRC_MF) ||
                    (act_src == osc_sel_pkg::SRC_MF) ||
                    (state_q != SW_IDLE &&
                     tgt_src == osc_sel_pkg::SRC_MF) ||
                    hf_need;
   assign lf_need = (internal_sel && req_src == osc_sel_pkg::SRC_LF) ||
                    (act_src == osc_sel_pkg::SRC_LF) ||
                    (state_q != SW_IDLE &&
                     tgt_src == osc_sel_pkg::SRC_LF) ||
                    LF_CONSUMER_REQ_IN;

   assign hf_rdy = hf_cnt_q >= W'(osc_sel_pkg::START_CYC);
   assign mf_rdy = mf_cnt_q >= W'(osc_sel_pkg::START_CYC);
   assign lf_rdy = lf_cnt_q >= W'(osc_sel_pkg::LF_START_CYC);

   always_comb begin
      unique case (tgt_src)
         osc_sel_pkg::SRC_HF: target_rdy = hf_rdy;
         osc_sel_pkg::SRC_MF: target_rdy = mf_rdy;
         osc_sel_pkg::SRC_LF: target_rdy = lf_rdy;
         default:             target_rdy = 1'b0;
      endcase
   end

   assign apb_access = PSEL_IN && PENABLE_IN && PREADY_OUT;
   assign apb_write  = apb_access && PWRITE_IN;

   // Control register
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         mult_sw_q <= 1'b0;
         freq_q    <= osc_sel_pkg::FREQ_RST;
         src_q     <= osc_sel_pkg::SRC_RST;
      end else if (apb_write && PADDR_IN == ofs_ctrl) begin
         mult_sw_q <= PWDATA_IN[osc_sel_pkg::CTRL_MULT_BIT];
         freq_q    <= PWDATA_IN[osc_sel_pkg::CTRL_FREQ_LSB +: 4];
         src_q     <= PWDATA_IN[osc_sel_pkg::CTRL_SRC_LSB +: 2];
      end
   end

   // Trim goes straight to the high/mid analog core; no settle flag
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         trim_q <= osc_sel_pkg::TRIM_RST;
      end else if (apb_write && PADDR_IN == ofs_trim) begin
         trim_q <= PWDATA_IN[5:0];
      end
   end

   // Warm-up counters stand in for the analog ready and accuracy signals
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         hf_cnt_q   <= '0;
         mf_cnt_q   <= '0;
         lf_cnt_q   <= '0;
         mult_cnt_q <= '0;
      end else begin
         hf_cnt_q   <= warm(hf_need, hf_cnt_q);
         mf_cnt_q   <= warm(mf_need, mf_cnt_q);
         lf_cnt_q   <= warm(lf_need, lf_cnt_q);
         mult_cnt_q <= warm(mult_on, mult_cnt_q);
      end
   end

   // Switch sequencer
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         state_q       <= SW_IDLE;
         target_q      <= osc_sel_pkg::FREQ_RST;
         active_freq_q <= osc_sel_pkg::FREQ_RST;
         sync_cnt_q    <= 2'h0;
      end else begin
         unique case (state_q)
            SW_IDLE: begin
               if (internal_sel && freq_q != active_freq_q) begin
                  target_q <= freq_q;
                  // Same oscillator: no start-up wait
                  if (src_of(freq_q) == act_src) begin
                     state_q <= SW_FALL;
                  end else begin
                     state_q <= SW_START;
                  end
               end
            end
            SW_START: begin
               if (target_rdy) begin
                  state_q <= SW_FALL;
               end
            end
            SW_FALL: begin
               sync_cnt_q <= 2'h0;
               state_q    <= SW_SYNC;
            end
            SW_SYNC: begin
               // Clock held low while the new one passes the synchroniser
               if (sync_cnt_q == osc_sel_pkg::SYNC_CYC - 2'h1) begin
                  active_freq_q <= target_q;
                  state_q       <= SW_DONE;
               end else begin
                  sync_cnt_q <= sync_cnt_q + 2'h1;
               end
            end
            SW_DONE: begin
               state_q <= SW_IDLE;
            end
         endcase
      end
   end

   // Status is frozen during a switch and refreshed once it completes
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         status_q <= 7'h00;
      end else if (state_q == SW_IDLE || state_q == SW_DONE) begin
         status_q[osc_sel_pkg::ST_MULT_RDY] <=
            mult_cnt_q >= W'(MULT_LOCK_CYC);
         status_q[osc_sel_pkg::ST_CFG_SRC] <=
            CFG_DEFAULT_SRC_IN != osc_sel_pkg::CFG_INTERNAL &&
            src_q == osc_sel_pkg::SRC_DEFAULT;
         status_q[osc_sel_pkg::ST_HF_RDY] <= hf_rdy;
         status_q[osc_sel_pkg::ST_HF_LOCK] <=
            hf_cnt_q >= W'(osc_sel_pkg::HF_LOCK_CYC);
         status_q[osc_sel_pkg::ST_MF_RDY] <= mf_rdy;
         status_q[osc_sel_pkg::ST_LF_RDY] <= lf_rdy;
         status_q[osc_sel_pkg::ST_HF_STABLE] <=
            hf_cnt_q >= W'(osc_sel_pkg::HF_STABLE_CYC);
      end
   end

   // APB slave: one wait state, answer registered
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
      end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
         PREADY_OUT  <= 1'b1;
         PRDATA_OUT  <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
         if (PADDR_IN == ofs_ctrl) begin
            PRDATA_OUT[7:0] <= {mult_sw_q, freq_q, 1'b0, src_q};
         end else if (PADDR_IN == ofs_status) begin
            PRDATA_OUT[6:0] <= status_q;
         end else if (PADDR_IN == ofs_trim) begin
            PRDATA_OUT[5:0] <= trim_q;
         end else begin
            PSLVERR_OUT <= 1'b1;
         end
      end else begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end
   end

   // Oscillator, multiplier and pin controls
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         HF_OSC_EN_OUT    <= 1'b0;
         MF_OSC_EN_OUT    <= 1'b0;
         LF_OSC_EN_OUT    <= 1'b0;
         MULT_EN_OUT      <= 1'b0;
         RC_CLK_EN_OUT    <= 1'b0;
         TRIM_OUT         <= osc_sel_pkg::TRIM_RST;
         INTERNAL_SRC_OUT <= 1'b0;
         CLOCK_IN_PIN_GPIO_OUT   <= 1'b0;
         CLOCK_OUT_PIN_FUNC_OUT  <= 1'b0;
      end else begin
         HF_OSC_EN_OUT    <= hf_need;
         MF_OSC_EN_OUT    <= mf_need;
         LF_OSC_EN_OUT    <= lf_need;
         MULT_EN_OUT      <= mult_on;
         // Sleep does not gate the peripheral RC clock
         RC_CLK_EN_OUT    <= PERIPH_RC_REQ_IN;
         // Trim feeds only the mid core and thus the high source
         TRIM_OUT         <= trim_q;
         INTERNAL_SRC_OUT <= internal_sel;
         CLOCK_IN_PIN_GPIO_OUT   <= internal_sel;
         CLOCK_OUT_PIN_FUNC_OUT  <= CFG_CLOCK_OUT_PIN_EN_IN;
      end
   end

   // Active selection seen by the clock mux
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         ACTIVE_FREQ_OUT  <= osc_sel_pkg::FREQ_RST;
         ACTIVE_MULT_OUT  <= 1'b0;
         CLK_HOLD_LOW_OUT <= 1'b0;
      end else begin
         ACTIVE_FREQ_OUT  <= active_freq_q;
         // With the force bit the 1110 code means the multiplied clock once locked, under select 00 and internal default
         ACTIVE_MULT_OUT  <= mult_on &&
                             active_freq_q == osc_sel_pkg::FREQ_8M_32M &&
                             mult_cnt_q >= W'(MULT_LOCK_CYC);
         CLK_HOLD_LOW_OUT <= state_q == SW_FALL || state_q == SW_SYNC;
      end
   end

endmodule : internal_osc_clock_select
`default_nettype wire

// File: logic/osc_sel_pkg.sv
// Constants shared by the internal oscillator selection block
package osc_sel_pkg;
   localparam int CLK_NS = 10;
   localparam int CNT_W  = 18;

   // Register byte offsets on the APB slave
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] TRIM_OFS   = 12'h008;

   // Control register fields
   localparam int CTRL_MULT_BIT = 7;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int CTRL_SRC_LSB  = 0;

   // Status register fields
   localparam int ST_MULT_RDY  = 6;
   localparam int ST_CFG_SRC   = 5;
   localparam int ST_HF_RDY    = 4;
   localparam int ST_HF_LOCK   = 3;
   localparam int ST_MF_RDY    = 2;
   localparam int ST_LF_RDY    = 1;
   localparam int ST_HF_STABLE = 0;

   // Reset values
   localparam logic [3:0] FREQ_RST = 4'h7;
   localparam logic [1:0] SRC_RST  = 2'h0;
   localparam logic [5:0] TRIM_RST = 6'h00;

   // Encodings
   localparam logic [1:0] CFG_INTERNAL = 2'h0;
   localparam logic [1:0] SRC_DEFAULT  = 2'h0;
   localparam logic [3:0] FREQ_8M_32M  = 4'hE;

   // Oscillator start-up and settling times
   localparam int START_NS     = 2000;
   localparam int LF_START_NS  = 1000;
   localparam int HF_LOCK_NS   = 5000;
   localparam int HF_STABLE_NS = 20000;
   localparam int MULT_LOCK_NS = 2000000;

   localparam int START_CYC     = (START_NS + CLK_NS - 1) / CLK_NS;
   localparam int LF_START_CYC  = (LF_START_NS + CLK_NS - 1) / CLK_NS;
   localparam int HF_LOCK_CYC   = (HF_LOCK_NS + CLK_NS - 1) / CLK_NS;
   localparam int HF_STABLE_CYC = (HF_STABLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int MULT_LOCK_CYC = (MULT_LOCK_NS + CLK_NS - 1) / CLK_NS;

   // Hold-low synchroniser length during a switch
   localparam logic [1:0] SYNC_CYC = 2'h2;

   typedef enum logic [3:0] {
      SRC_NONE = 4'b0001,
      SRC_HF   = 4'b0010,
      SRC_MF   = 4'b0100,
      SRC_LF   = 4'b1000
   } osc_src_e;
endpackage : osc_sel_pkg

// File: tb/internal_osc_clock_select_tb.sv
// Self-checking bench for the oscillator select block
`timescale 1ns/1ns
`default_nettype none
module internal_osc_clock_select_tb;
   localparam logic [11:0] CT = osc_sel_pkg::CTRL_OFS;
   localparam logic [11:0] ST = osc_sel_pkg::STATUS_OFS;
   localparam logic [11:0] TR = osc_sel_pkg::TRIM_OFS;
   localparam int          SC = osc_sel_pkg::START_CYC;
   logic        clk, rst_b, psel, pen, pwr, peripheral_rc_clock, ckoe, lfq, rcq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er, hf_en, mf_en, lf_en, mult_en, rc_en;
   logic        amult, isrc, hold, gpio, ckf;
   logic [5:0]  trim;
   logic [3:0]  afreq;
   logic [1:0]  cfg;
   int          errors, n_tests, n, cyc;

   internal_osc_clock_select #(.MULT_LOCK_CYC(50)) u_dut (
      .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .CFG_DEFAULT_SRC_IN(cfg), .CFG_MULT_FORCE_IN(peripheral_rc_clock),
      .CFG_CLOCK_OUT_PIN_EN_IN(ckoe), .LF_CONSUMER_REQ_IN(lfq), .PERIPH_RC_REQ_IN(rcq),
      .HF_OSC_EN_OUT(hf_en), .MF_OSC_EN_OUT(mf_en), .LF_OSC_EN_OUT(lf_en),
      .MULT_EN_OUT(mult_en), .RC_CLK_EN_OUT(rc_en), .TRIM_OUT(trim),
      .ACTIVE_FREQ_OUT(afreq), .ACTIVE_MULT_OUT(amult), .INTERNAL_SRC_OUT(isrc),
      .CLK_HOLD_LOW_OUT(hold), .CLOCK_IN_PIN_GPIO_OUT(gpio), .CLOCK_OUT_PIN_FUNC_OUT(ckf));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_in(input int got, input int lo, input int hi);
      n_tests++;
      if (got < lo || got > hi) begin
         errors++;
         $display("MISMATCH t=%0t cycles=%h bounds=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_in

   // Leading edge keeps the previous release and the next setup apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wait_for(input int s, input logic [3:0] v);
      logic [3:0] cur;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         cur = (s == 0) ? afreq : (s == 1) ? {3'h0, amult} : {3'h0, mult_en};
      end while (cur !== v && n < 3000);
      // A wait that runs out is a failed expectation in its own right
      n_tests++;
      if (cur !== v) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, cur, v);
      end
   endtask : wait_for

   initial begin
      {rst_b, psel, pen, pwr, peripheral_rc_clock, ckoe, lfq, rcq} = 8'h00;
      paddr = 12'h000;
      cfg = osc_sel_pkg::CFG_INTERNAL;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      chk(32'(afreq), 32'h7);
      apb(1'b0, CT, 32'h0); chk(rd, 32'h38);
      apb(1'b0, TR, 32'h0); chk(rd, 32'h0);
      repeat (300) @(posedge clk);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h4, 32'h4);
      chk(32'(mf_en), 32'h1);
      apb(1'b1, CT, 32'h30); wait_for(0, 4'h6); chk_in(n, 1, 20);
      apb(1'b1, CT, 32'h78); wait_for(0, 4'hF); chk_in(n, SC - 2, SC + 30);
      chk(32'(hf_en), 32'h1);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h1D, 32'h14);
      repeat (osc_sel_pkg::HF_STABLE_CYC) @(posedge clk);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h19, 32'h19);
      apb(1'b1, TR, 32'h1F); repeat (2) @(posedge clk); chk(32'(trim), 32'h1F);
      apb(1'b1, TR, 32'hFFFF_FFE0); apb(1'b0, TR, 32'h0); chk(rd, 32'h20);
      chk(32'(trim), 32'h20);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h19, 32'h19);
      apb(1'b1, 12'h00C, 32'hFF); chk(32'(er), 32'h1);
      apb(1'b0, 12'h00C, 32'h0); chk({rd[30:0], er}, 32'h1);
      apb(1'b1, ST, 32'h0); chk(32'(er), 32'h0);
      lfq <= 1'b1;
      apb(1'b1, CT, 32'h02); wait_for(0, 4'h0); chk(32'(lf_en), 32'h1);
      apb(1'b1, CT, 32'h3A); wait_for(0, 4'h7); chk(32'(lf_en), 32'h1);
      lfq <= 1'b0;
      apb(1'b1, CT, 32'hF0); wait_for(1, 4'h1); chk(32'(amult), 32'h1);
      chk(32'(mult_en), 32'h1);
      chk(32'(lf_en), 32'h0);
      apb(1'b1, CT, 32'hF2); wait_for(1, 4'h0); chk_in(n, 1, 300);
      peripheral_rc_clock <= 1'b1;
      apb(1'b1, CT, 32'h70); wait_for(1, 4'h1); chk(32'(mult_en), 32'h1);
      peripheral_rc_clock <= 1'b0;
      wait_for(2, 4'h0); chk(32'(mult_en), 32'h0);
      rcq <= 1'b1;
      ckoe <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(rc_en), 32'h1);
      chk({30'h0, gpio, ckf}, 32'h3);
      rcq <= 1'b0;
      ckoe <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, rc_en, ckf}, 32'h0);
      chk({30'h0, gpio, isrc}, 32'h3);
      cfg <= 2'h1;
      repeat (3) @(posedge clk);
      chk({30'h0, gpio, isrc}, 32'h0);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h20, 32'h20);
      cfg <= osc_sel_pkg::CFG_INTERNAL;
      repeat (3) @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, CT, 32'h0); chk(rd, 32'h38);
      apb(1'b0, TR, 32'h0); chk(rd, 32'h0);
      give_verdict();
   end
endmodule : internal_osc_clock_select_tb
`default_nettype wire

// File: tb/osc_sel_sva.sv
// Assertions on the ports of the oscillator select block
`timescale 1ns/1ns
`default_nettype none
module osc_sel_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic              CLK_SYS_IN,
   input wire logic              RST_B_IN,
   input wire logic              PSEL_IN,
   input wire logic              PENABLE_IN,
   input wire logic              PWRITE_IN,
   input wire logic [ADDR_W-1:0] PADDR_IN,
   input wire logic              PREADY_OUT,
   input wire logic              PSLVERR_OUT,
   input wire logic              CFG_CLOCK_OUT_PIN_EN_IN,
   input wire logic              PERIPH_RC_REQ_IN,
   input wire logic              RC_CLK_EN_OUT,
   input wire logic [5:0]        TRIM_OUT,
   input wire logic [3:0]        ACTIVE_FREQ_OUT,
   input wire logic              ACTIVE_MULT_OUT,
   input wire logic              CLK_HOLD_LOW_OUT,
   input wire logic              CLOCK_OUT_PIN_FUNC_OUT
);
   logic wr_trim;
   assign wr_trim = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
                    && PADDR_IN == ADDR_W'(osc_sel_pkg::TRIM_OFS);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   property p_rdy; PSEL_IN && PENABLE_IN && !PREADY_OUT |-> ##[1:2] PREADY_OUT; endproperty
   a_rdy: assert property (p_rdy) else $error("access not answered");
   property p_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_inacc; PREADY_OUT |-> PSEL_IN && PENABLE_IN; endproperty
   a_inacc: assert property (p_inacc) else $error("ready outside access");
   property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rst_freq; !$past(RST_B_IN) |-> ACTIVE_FREQ_OUT == osc_sel_pkg::FREQ_RST; endproperty
   a_rst_freq: assert property (p_rst_freq) else $error("bad reset frequency");
   property p_rc; $past(RST_B_IN, 2) && $past(RST_B_IN) |-> RC_CLK_EN_OUT == $past(PERIPH_RC_REQ_IN); endproperty
   a_rc: assert property (p_rc) else $error("rc clock enable does not follow request");
   property p_clock_out_pin; $past(RST_B_IN) && $rose(CFG_CLOCK_OUT_PIN_EN_IN) |=> CLOCK_OUT_PIN_FUNC_OUT; endproperty
   a_clock_out_pin: assert property (p_clock_out_pin) else $error("clock out pin not enabled");
   property p_trim; $past(RST_B_IN) && $changed(TRIM_OUT) |-> $past(wr_trim) || $past(wr_trim, 2); endproperty
   a_trim: assert property (p_trim) else $error("trim changed without write");
   property p_hold; $rose(CLK_HOLD_LOW_OUT) |-> CLK_HOLD_LOW_OUT[*3] ##1 !CLK_HOLD_LOW_OUT; endproperty
   a_hold: assert property (p_hold) else $error("hold low not three cycles");
   property p_switch; $past(RST_B_IN) && $changed(ACTIVE_FREQ_OUT)
      |-> $past(CLK_HOLD_LOW_OUT) || $past(CLK_HOLD_LOW_OUT, 2) || $past(CLK_HOLD_LOW_OUT, 3); endproperty
   a_switch: assert property (p_switch) else $error("frequency changed without hold");
   property p_mult; ACTIVE_MULT_OUT |-> ACTIVE_FREQ_OUT == osc_sel_pkg::FREQ_8M_32M; endproperty
   a_mult: assert property (p_mult) else $error("multiplier on wrong code");
endmodule : osc_sel_sva
bind internal_osc_clock_select osc_sel_sva #(.ADDR_W(ADDR_W)) u_sva (.CLK_SYS_IN, .RST_B_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .CFG_CLOCK_OUT_PIN_EN_IN, .PERIPH_RC_REQ_IN,
   .RC_CLK_EN_OUT, .TRIM_OUT, .ACTIVE_FREQ_OUT, .ACTIVE_MULT_OUT, .CLK_HOLD_LOW_OUT, .CLOCK_OUT_PIN_FUNC_OUT);
`default_nettype wire
